// ---- pkg/sodg_pkg.sv ----
package sodg_pkg;

  // Deviation counter and threshold widths.
  localparam int DEV_W = 32;
  localparam int LVL_W = 30;
  localparam int SPD_W = 14;
  localparam int PCT_W = 7;

  // Setting ranges and defaults.
  localparam logic [LVL_W-1:0] LVL_MIN = 30'h00000001;
  localparam logic [LVL_W-1:0] LVL_MAX = 30'h3FFFFFFF;
  localparam logic [LVL_W-1:0] LVL_DEF = 30'h00500000;
  localparam logic [SPD_W-1:0] SPD_MAX = 14'h2710;
  localparam logic [SPD_W-1:0] SPD_DEF = 14'h2710;
  localparam logic [PCT_W-1:0] PCT_MIN = 7'h0A;
  localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;
  localparam logic [PCT_W-1:0] PCT_DEF = 7'h64;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

  // Guard states.
  typedef enum logic [1:0] {
    SODG_OFF = 2'b00,
    SODG_LIMIT = 2'b01,
    SODG_RUN = 2'b10,
    SODG_FAULT = 2'b11
  } sodg_state_t;

endpackage

// ---- pkg/sodg_set_if.sv ----
// Carries the live, clamped settings from the settings holder to the guard.
interface sodg_set_if;
  logic [sodg_pkg::LVL_W-1:0] son_alarm_lvl;
  logic [sodg_pkg::LVL_W-1:0] son_warn_lvl;
  logic [sodg_pkg::LVL_W-1:0] gen_ovf_lvl;
  logic [sodg_pkg::SPD_W-1:0] speed_limit;
  modport src (output son_alarm_lvl, output son_warn_lvl, output gen_ovf_lvl, output speed_limit);
  modport dst (input son_alarm_lvl, input son_warn_lvl, input gen_ovf_lvl, input speed_limit);
endinterface

// ---- src/sodg_settings.sv ----
// Holds the settings in flops; writes take effect on the next edge, no restart.
module sodg_settings (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Write port.
  input wire logic i_wr,
  input wire logic [sodg_pkg::LVL_W-1:0] i_alarm_lvl,
  input wire logic [sodg_pkg::PCT_W-1:0] i_warn_pct,
  input wire logic [sodg_pkg::LVL_W-1:0] i_ovf_lvl,
  input wire logic [sodg_pkg::SPD_W-1:0] i_spd_rot,
  input wire logic [sodg_pkg::SPD_W-1:0] i_spd_lin,
  input wire logic i_linear,
  // Live settings.
  sodg_set_if.src set
);

  logic [sodg_pkg::LVL_W-1:0] alarm_q;
  logic [sodg_pkg::LVL_W-1:0] ovf_q;
  logic [sodg_pkg::PCT_W-1:0] pct_q;
  logic [sodg_pkg::SPD_W-1:0] rot_q;
  logic [sodg_pkg::SPD_W-1:0] lin_q;
  logic [sodg_pkg::LVL_W+sodg_pkg::PCT_W-1:0] prod;

  // Out-of-range levels saturate to the nearest legal value.
  function automatic logic [sodg_pkg::LVL_W-1:0] clamp_lvl(input logic [sodg_pkg::LVL_W-1:0] v);
    clamp_lvl = (v < sodg_pkg::LVL_MIN) ? sodg_pkg::LVL_MIN : v;
  endfunction

  function automatic logic [sodg_pkg::SPD_W-1:0] clamp_spd(input logic [sodg_pkg::SPD_W-1:0] v);
    clamp_spd = (v > sodg_pkg::SPD_MAX) ? sodg_pkg::SPD_MAX : v;
  endfunction

  // Setting registers; a write is live from the next cycle.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      alarm_q <= sodg_pkg::LVL_DEF;
      ovf_q <= sodg_pkg::LVL_DEF;
      pct_q <= sodg_pkg::PCT_DEF;
      rot_q <= sodg_pkg::SPD_DEF;
      lin_q <= sodg_pkg::SPD_DEF;
    end else if (i_wr) begin
      alarm_q <= clamp_lvl(i_alarm_lvl);
      ovf_q <= clamp_lvl(i_ovf_lvl);
      pct_q <= (i_warn_pct < sodg_pkg::PCT_MIN) ? sodg_pkg::PCT_MIN :
               (i_warn_pct > sodg_pkg::PCT_MAX) ? sodg_pkg::PCT_MAX : i_warn_pct;
      rot_q <= clamp_spd(i_spd_rot);
      lin_q <= clamp_spd(i_spd_lin);
    end
  end

  // Warning level is alarm level times percent over one hundred.
  assign prod = alarm_q * pct_q;
  assign set.son_alarm_lvl = alarm_q;
  assign set.gen_ovf_lvl = ovf_q;
  assign set.son_warn_lvl = sodg_pkg::LVL_W'(prod / sodg_pkg::PCT_FULL);
  assign set.speed_limit = i_linear ? lin_q : rot_q;

endmodule

// ---- src/sodg_guard.sv ----
// Functional notes
// - Servo-on alarm threshold 1 to 2^30-1, default 5242880, live immediately.
// - At servo on, alarm if deviation exceeded threshold while servo was off.
// - Nonzero deviation at servo on caps speed at servo-on speed limit.
// - Speed limit 0 to 10000, default 10000, rpm rotary or mm/s linear.
// - During limit, reference arriving with deviation over general level raises alarm.
// - Warning percent 10 to 100, default 100, live immediately.
// - Loop returns motor to origin; threshold restricts that motion.
// - General overflow alarm when deviation exceeds level, default 5242880.
// - Deviation is commanded reference minus measured position.
// - Overflow flags an error and stops the motor.
module sodg_guard (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Settings write port.
  input wire logic i_set_wr,
  input wire logic [sodg_pkg::LVL_W-1:0] i_servo_on_dev_alarm_level,
  input wire logic [sodg_pkg::PCT_W-1:0] i_servo_on_dev_warn_percent,
  input wire logic [sodg_pkg::LVL_W-1:0] i_general_dev_overflow_level,
  input wire logic [sodg_pkg::SPD_W-1:0] i_servo_on_speed_limit_rotary,
  input wire logic [sodg_pkg::SPD_W-1:0] i_servo_on_speed_limit_linear,
  input wire logic i_linear_motor,
  // Loop inputs.
  input wire logic i_servo_on,
  input wire logic i_pos_ctrl,
  input wire logic signed [sodg_pkg::DEV_W-1:0] i_pos_ref,
  input wire logic signed [sodg_pkg::DEV_W-1:0] i_pos_fb,
  input wire logic i_ref_valid,
  input wire logic i_alarm_clr,
  // Outputs.
  output logic signed [sodg_pkg::DEV_W-1:0] o_deviation,
  output logic o_speed_limit_active,
  output logic [sodg_pkg::SPD_W-1:0] o_speed_limit,
  output logic o_servo_on_dev_warn,
  output logic o_servo_on_dev_alarm,
  output logic o_speed_limit_dev_alarm,
  output logic o_general_dev_overflow_alarm,
  output logic o_motor_stop
);

  sodg_set_if set ();

  sodg_settings u_set (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_wr(i_set_wr),
    .i_alarm_lvl(i_servo_on_dev_alarm_level),
    .i_warn_pct(i_servo_on_dev_warn_percent),
    .i_ovf_lvl(i_general_dev_overflow_level),
    .i_spd_rot(i_servo_on_speed_limit_rotary),
    .i_spd_lin(i_servo_on_speed_limit_linear),
    .i_linear(i_linear_motor),
    .set(set.src)
  );

  sodg_pkg::sodg_state_t state_q;
  logic servo_on_q;
  logic off_exceed_q;
  logic [sodg_pkg::DEV_W-1:0] dev_mag;
  logic over_alarm;
  logic over_warn;
  logic over_gen;
  logic turn_on;
  logic any_alarm;
  logic son_trip;
  logic lim_trip;
  logic gen_trip;
  logic alarm_clr_ok;

  // Absolute value of the deviation, used against every threshold.
  function automatic logic [sodg_pkg::DEV_W-1:0] mag(input logic signed [sodg_pkg::DEV_W-1:0] v);
    mag = v[sodg_pkg::DEV_W-1] ? sodg_pkg::DEV_W'(-v) : v;
  endfunction

  // Threshold compares and the trip terms that raise an alarm in this cycle.
  assign dev_mag = mag(o_deviation);
  assign over_alarm = dev_mag > {2'h0, set.son_alarm_lvl};
  assign over_warn = dev_mag > {2'h0, set.son_warn_lvl};
  assign over_gen = dev_mag > {2'h0, set.gen_ovf_lvl};
  assign turn_on = i_servo_on && !servo_on_q;
  assign any_alarm = o_servo_on_dev_alarm || o_speed_limit_dev_alarm || o_general_dev_overflow_alarm;
  assign son_trip = (state_q == sodg_pkg::SODG_OFF) && turn_on && (off_exceed_q || over_alarm);
  assign lim_trip = (state_q == sodg_pkg::SODG_LIMIT) && i_servo_on && i_ref_valid && over_gen;
  assign gen_trip = (state_q == sodg_pkg::SODG_RUN) && i_servo_on && i_pos_ctrl && over_gen;
  assign alarm_clr_ok = i_alarm_clr && !i_servo_on;

  // Deviation register; the wrap of the counters is harmless in two's complement.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_deviation <= '0;
    end else begin
      o_deviation <= i_pos_ref - i_pos_fb;
    end
  end

  // Servo edge detect; it also marks which servo state the lagging deviation belongs to.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      servo_on_q <= 1'b0;
    end else begin
      servo_on_q <= i_servo_on;
    end
  end

  // Sticky note that the deviation grew too far while off. The deviation register lags one cycle,
  // so it is paired with the delayed servo state; the last on-time deviation is never booked as off-time.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      off_exceed_q <= 1'b0;
    end else if (!servo_on_q && over_alarm) begin
      off_exceed_q <= 1'b1;
    end else if (servo_on_q) begin
      off_exceed_q <= 1'b0;
    end
  end

  // Guard state machine. An alarm holds the motor stopped until cleared with servo off.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= sodg_pkg::SODG_OFF;
    end else begin
      case (state_q)
        sodg_pkg::SODG_OFF: begin
          if (turn_on) begin
            if (off_exceed_q || over_alarm) begin
              state_q <= sodg_pkg::SODG_FAULT;
            end else if (o_deviation != '0) begin
              state_q <= sodg_pkg::SODG_LIMIT;
            end else begin
              state_q <= sodg_pkg::SODG_RUN;
            end
          end
        end
        sodg_pkg::SODG_LIMIT: begin
          if (!i_servo_on) begin
            state_q <= sodg_pkg::SODG_OFF;
          end else if (i_ref_valid && over_gen) begin
            state_q <= sodg_pkg::SODG_FAULT;
          end else if (o_deviation == '0) begin
            state_q <= sodg_pkg::SODG_RUN;
          end
        end
        sodg_pkg::SODG_RUN: begin
          if (!i_servo_on) begin
            state_q <= sodg_pkg::SODG_OFF;
          end else if (i_pos_ctrl && over_gen) begin
            state_q <= sodg_pkg::SODG_FAULT;
          end
        end
        sodg_pkg::SODG_FAULT: begin
          if (i_alarm_clr && !i_servo_on) begin
            state_q <= sodg_pkg::SODG_OFF;
          end
        end
        default: begin
          state_q <= sodg_pkg::SODG_OFF;
        end
      endcase
    end
  end

  // Servo-on alarm is sticky; a new cause in the clear cycle wins over the clear.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_servo_on_dev_alarm <= 1'b0;
    end else if (son_trip) begin
      o_servo_on_dev_alarm <= 1'b1;
    end else if (alarm_clr_ok) begin
      o_servo_on_dev_alarm <= 1'b0;
    end
  end

  // Speed-limit deviation alarm, raised only while the servo-on cap is in force.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_speed_limit_dev_alarm <= 1'b0;
    end else if (lim_trip) begin
      o_speed_limit_dev_alarm <= 1'b1;
    end else if (alarm_clr_ok) begin
      o_speed_limit_dev_alarm <= 1'b0;
    end
  end

  // General overflow alarm, judged only in position control once the cap has ended.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_general_dev_overflow_alarm <= 1'b0;
    end else if (gen_trip) begin
      o_general_dev_overflow_alarm <= 1'b1;
    end else if (alarm_clr_ok) begin
      o_general_dev_overflow_alarm <= 1'b0;
    end
  end

  // The warning is advisory, so a clear drops it even with the servo on.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_servo_on_dev_warn <= 1'b0;
    end else if (turn_on && over_warn) begin
      o_servo_on_dev_warn <= 1'b1;
    end else if (i_alarm_clr) begin
      o_servo_on_dev_warn <= 1'b0;
    end
  end

  // Speed cap flag follows the limit state one cycle later.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_speed_limit_active <= 1'b0;
    end else begin
      o_speed_limit_active <= (state_q == sodg_pkg::SODG_LIMIT);
    end
  end

  // Selected limit setting; the motor type input picks rotary or linear live.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_speed_limit <= sodg_pkg::SPD_DEF;
    end else begin
      o_speed_limit <= set.speed_limit;
    end
  end

  // Stop command. The trip terms raise it in the same cycle as the alarm, so the motor gets
  // no extra step between the cause and the stop.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_motor_stop <= 1'b1;
    end else begin
      o_motor_stop <= (state_q == sodg_pkg::SODG_FAULT) || any_alarm || son_trip || lim_trip
                      || gen_trip || !i_servo_on;
    end
  end

endmodule

// ---- tb/sodg_chk.sv ----
// Watches the guard's ports; the setting inputs must stay as they were last written.
module sodg_chk (
  // Clock, reset and inputs.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [29:0] i_servo_on_dev_alarm_level,
  input wire logic [6:0] i_servo_on_dev_warn_percent,
  input wire logic [29:0] i_general_dev_overflow_level,
  input wire logic i_servo_on,
  input wire logic i_alarm_clr,
  input wire logic signed [31:0] i_pos_ref,
  input wire logic signed [31:0] i_pos_fb,
  // Outputs under watch.
  input wire logic signed [31:0] o_deviation,
  input wire logic o_speed_limit_active,
  input wire logic o_servo_on_dev_warn,
  input wire logic o_servo_on_dev_alarm,
  input wire logic o_speed_limit_dev_alarm,
  input wire logic o_general_dev_overflow_alarm,
  input wire logic o_motor_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mag;
  logic signed [31:0] diff;
  logic [36:0] warn_lvl;
  // Integer division here matches the rounding the guard uses for the warning level.
  always_comb begin
    mag = o_deviation[31] ? -o_deviation : o_deviation;
    diff = i_pos_ref - i_pos_fb;
    warn_lvl = 37'(i_servo_on_dev_alarm_level) * i_servo_on_dev_warn_percent / 100;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  dev_calc_a: assert property (!$past(i_rst) |-> o_deviation == $past(diff))
    else $error("deviation differs from reference minus feedback");
  son_alarm_a: assert property ($rose(i_servo_on) && mag > i_servo_on_dev_alarm_level |=> o_servo_on_dev_alarm)
    else $error("servo-on alarm missing");
  son_limit_a: assert property ($rose(i_servo_on) && mag != 0 && mag <= i_servo_on_dev_alarm_level
    |-> ##2 o_speed_limit_active) else $error("speed limit not applied");
  alarm_hold_a: assert property (o_servo_on_dev_alarm && i_servo_on |=> o_servo_on_dev_alarm)
    else $error("alarm dropped while servo on");
  alarm_clr_a: assert property ($fell(o_servo_on_dev_alarm) |-> $past(i_alarm_clr) && !$past(i_servo_on))
    else $error("alarm cleared without cause");
  ovf_cause_a: assert property ($rose(o_general_dev_overflow_alarm)
    |-> $past(mag) > $past(i_general_dev_overflow_level)) else $error("overflow alarm without cause");
  spd_cause_a: assert property ($rose(o_speed_limit_dev_alarm)
    |-> $past(mag) > $past(i_general_dev_overflow_level)) else $error("limit alarm without cause");
  warn_cause_a: assert property ($rose(o_servo_on_dev_warn) |-> $past(mag) > $past(warn_lvl))
    else $error("warning without cause");
  stop_alarm_a: assert property (o_servo_on_dev_alarm || o_speed_limit_dev_alarm
    || o_general_dev_overflow_alarm |=> o_motor_stop) else $error("motor not stopped on alarm");
  trip_stop_a: assert property ($rose(o_servo_on_dev_alarm) || $rose(o_speed_limit_dev_alarm)
    || $rose(o_general_dev_overflow_alarm) |-> o_motor_stop) else $error("stop late after alarm");
endmodule

// ---- tb/sodg_motor.sv ----
// Motor with encoder: follows the reference one unit per cycle unless stopped.
module sodg_motor (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_stop,
  input wire logic signed [31:0] i_pos_ref,
  output logic signed [31:0] o_pos_fb
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow tracking keeps a deviation alive long enough for the guard to judge it.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pos_fb <= 32'sh0;
    end else if (!i_stop && o_pos_fb != i_pos_ref) begin
      o_pos_fb <= o_pos_fb + ((i_pos_ref > o_pos_fb) ? 32'sh1 : -32'sh1);
    end
  end
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, lin = 0, son = 0, pc = 0, rv = 0, clr = 0;
  logic signed [31:0] ref_p = 0, fb, dev;
  logic act, warn, al, sal, gal, stp;
  logic [13:0] spd;
  logic [6:0] wpc = 7'h32;
  int failures = 0, check_count = 0;
  sodg_motor u_mot (.i_ref_clk(clk), .i_rst(rst), .i_stop(stp), .i_pos_ref(ref_p), .o_pos_fb(fb));
  sodg_guard u_dut (.i_ref_clk(clk), .i_rst(rst), .i_set_wr(wr), .i_servo_on_dev_alarm_level(30'h64),
    .i_servo_on_dev_warn_percent(wpc), .i_general_dev_overflow_level(30'hC8),
    .i_servo_on_speed_limit_rotary(14'h12C), .i_servo_on_speed_limit_linear(14'h4D), .i_linear_motor(lin),
    .i_servo_on(son), .i_pos_ctrl(pc), .i_pos_ref(ref_p), .i_pos_fb(fb), .i_ref_valid(rv), .i_alarm_clr(clr),
    .o_deviation(dev), .o_speed_limit_active(act), .o_speed_limit(spd), .o_servo_on_dev_warn(warn),
    .o_servo_on_dev_alarm(al), .o_speed_limit_dev_alarm(sal), .o_general_dev_overflow_alarm(gal),
    .o_motor_stop(stp));
  // Clock at 250 MHz.
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Servo off, hold the reference at the feedback and pulse clear.
  task automatic park();
    son = 0;
    ref_p = fb;
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(3);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the fewer than a hundred cycles the tests need.
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
  // Reset values, then one write of the test settings.
  task automatic test_reset();
    chk("stop", stp, 1);
    chk("limit default", spd, 32'h2710);
    wr = 1;
    pc = 1;
    cyc(1);
    wr = 0;
    $display("reset test done");
  endtask
  // Excess while off trips at turn-on; the stop must not drop for even one cycle.
  task automatic test_son_alarm();
    ref_p = fb + 150;
    cyc(3);
    son = 1;
    cyc(1);
    chk("stop at turn-on", stp, 1);
    cyc(1);
    chk("son alarm", al, 1);
    chk("son warn", warn, 1);
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(1);
    chk("alarm kept", al, 1);
    chk("stop", stp, 1);
    park();
    chk("alarm cleared", al, 0);
    $display("servo-on alarm test done");
  endtask
  // Small residual deviation: the cap applies until the motor has worked it off.
  task automatic test_speed_limit();
    ref_p = fb + 5;
    cyc(3);
    son = 1;
    cyc(3);
    chk("limit on", act, 1);
    chk("stop", stp, 0);
    chk("rotary limit", spd, 32'h12C);
    lin = 1;
    cyc(2);
    chk("linear limit", spd, 32'h4D);
    lin = 0;
    for (int i = 0; i < 20 && act; i++) cyc(1);
    chk("limit off", act, 0);
    chk("deviation", dev, 0);
    park();
    $display("speed limit test done");
  endtask
  // A reference that pushes the deviation past the general level while capped.
  task automatic test_limit_alarm();
    ref_p = fb + 40;
    cyc(3);
    son = 1;
    cyc(3);
    ref_p = ref_p + 300;
    rv = 1;
    cyc(3);
    rv = 0;
    cyc(2);
    chk("limit alarm", sal, 1);
    chk("stop", stp, 1);
    park();
    $display("limit alarm test done");
  endtask
  // A percent below the floor is raised to ten, so a deviation of eight gives no warning.
  task automatic test_warn_floor();
    wpc = 7'h05;
    wr = 1;
    cyc(1);
    wr = 0;
    ref_p = fb + 8;
    cyc(3);
    son = 1;
    cyc(2);
    chk("warn at floor", warn, 0);
    chk("limit on", act, 1);
    park();
    $display("warning floor test done");
  endtask
  // Overflow in run is judged only in position control.
  task automatic test_overflow();
    son = 1;
    pc = 0;
    cyc(4);
    ref_p = fb + 500;
    cyc(4);
    chk("overflow outside position mode", gal, 0);
    pc = 1;
    cyc(2);
    chk("overflow alarm", gal, 1);
    cyc(1);
    chk("stop", stp, 1);
    $display("overflow test done");
  endtask
  initial begin
    cyc(16);
    rst = 0;
    test_reset();
    test_son_alarm();
    test_speed_limit();
    test_limit_alarm();
    test_warn_floor();
    test_overflow();
    wrap_up();
  end
endmodule
bind sodg_guard sodg_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_servo_on_dev_alarm_level(i_servo_on_dev_alarm_level), .i_servo_on_dev_warn_percent(i_servo_on_dev_warn_percent),
  .i_general_dev_overflow_level(i_general_dev_overflow_level), .i_servo_on(i_servo_on), .i_alarm_clr(i_alarm_clr),
  .i_pos_ref(i_pos_ref), .i_pos_fb(i_pos_fb), .o_deviation(o_deviation), .o_speed_limit_active(o_speed_limit_active),
  .o_servo_on_dev_warn(o_servo_on_dev_warn), .o_servo_on_dev_alarm(o_servo_on_dev_alarm),
  .o_speed_limit_dev_alarm(o_speed_limit_dev_alarm), .o_general_dev_overflow_alarm(o_general_dev_overflow_alarm),
  .o_motor_stop(o_motor_stop));
